// ---- design/irc_defs.svh ----
// Offsets, field positions, reset values and source maps of the interrupt request control.
// Assumes a 32-bit AHB-Lite bus with one aligned word per 8-bit register.
`ifndef IRC_DEFS_SVH
`define IRC_DEFS_SVH

`define IRC_OFF_EDGE 8'h00
`define IRC_OFF_CTRL0 8'h04
`define IRC_OFF_GRP0 8'h14
`define IRC_REG_STRIDE 8'h04
`define IRC_RST_REG 8'h00
`define IRC_RST_RDATA 32'h00000000

`define IRC_BIT_GIE 0
`define IRC_EN_SHIFT 4
`define IRC_EN_SHIFT0 3
`define IRC_GRP_FLAG_LSB 4
`define IRC_GRP_EN_LSB 0
`define IRC_EDGE_A_LSB 0
`define IRC_EDGE_B_LSB 2

// Per primary source, index 13 first: control register number and flag bit
`define IRC_PRIM_REG {2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, \
	2'h0, 2'h0, 2'h0}
`define IRC_PRIM_BIT {3'h6, 3'h5, 3'h4, 3'h7, 3'h6, 3'h5, 3'h4, 3'h7, 3'h6, 3'h5, 3'h4, \
	3'h4, 3'h6, 3'h5}
// Primary index of pin A, pin B, each internal source and each group
`define IRC_PIN_A_PRIM 4'h0
`define IRC_PIN_B_PRIM 4'h1
`define IRC_INT_PRIM {4'hA, 4'h9, 4'h8, 4'h4, 4'h3, 4'h2}
`define IRC_GRP_PRIM {4'hD, 4'hC, 4'hB, 4'h7, 4'h6, 4'h5}
// Member slots present in each group, group 5 first
`define IRC_GRP_SLOTS {3'h3, 3'h7, 3'h7, 3'h3, 3'h3, 3'h3}

`endif

// ---- design/irc_pkg.sv ----
// Types shared by the interrupt request control and its users.
// Assumes irc_defs.svh supplies the numeric constants.
package irc_pkg;
	typedef struct packed {
		logic valid;
		logic [3:0] vector;
	} irc_req_s;
	typedef logic [7:0] irc_byte_t;
endpackage

// ---- design/irc_interrupt_request_control.sv ----
// Interrupt request flags, enables, edge detection and vector request to the core.
// Assumes a single AHB-Lite master, one clock, core acknowledges the vector it takes.
//
// Notes on behaviour
// - Pin B edge select at bits 3:2: 00 off, 01 rise, 10 fall, 11 both.
// - Pin A edge select at bits 1:0, same encoding as pin B.
// - Control 0: pin B, pin A, comparator 0 flags bits 6..4, enables 3..1.
// - Control 1: group 1, group 0, low voltage, serial flags 7..4, enables 3..0.
// - Four primary control registers, six group registers, one edge select register.
// - Some sources own a vector; grouped sources share their group vector.
// - Six groups numbered 0 to 5, each with request flag and enable.
// - The two pins raise requests on their configured edge.
// - Edge select bits 7..4 and control 0 bit 7 read zero.
// - Every source has an enable and a flag reading one while pending.
// - Flags latch even when disabled, but raise no interrupt then.
// - Servicing clears the global enable; new requests still latch.
// - Control 3: groups 5, 4, 3 flags at bits 6..4, enables 2..0.
`timescale 1ns/1ns
`include "irc_defs.svh"

module irc_interrupt_request_control import irc_pkg::*; #(
	parameter int NUM_PRIM = 14,
	parameter int NUM_GRP = 6,
	parameter int NUM_INT = 6
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic ext_irq_pin_a_in,
	input wire logic ext_irq_pin_b_in,
	input wire logic [NUM_INT-1:0] int_event_in,
	input wire logic [NUM_GRP*3-1:0] member_event_in,
	input wire logic irq_ack_in,
	output irc_req_s irq_req_out
);

	localparam logic [13:0][1:0] PREG = `IRC_PRIM_REG;
	localparam logic [13:0][2:0] PBIT = `IRC_PRIM_BIT;
	localparam logic [5:0][3:0] INTP = `IRC_INT_PRIM;
	localparam logic [5:0][3:0] GPRIM = `IRC_GRP_PRIM;
	localparam logic [5:0][2:0] SLOTS = `IRC_GRP_SLOTS;

	generate
		if (NUM_PRIM != 14 || NUM_GRP != 6 || NUM_INT != 6) begin : g_bad_cfg
			$error("source counts are fixed by the register layout");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [2:0] pa_s;
	logic [2:0] pb_s;
	logic [3:0] edge_sel;
	logic gie;
	logic [13:0] pflag;
	logic [13:0] penable;
	logic [5:0][2:0] mflag;
	logic [5:0][2:0] men;
	logic wr_q;
	logic [7:0] wa_q;
	irc_req_s next_req;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pa_s <= 3'h0;
			pb_s <= 3'h0;
		end else begin
			pa_s <= {pa_s[1:0], ext_irq_pin_a_in};
			pb_s <= {pb_s[1:0], ext_irq_pin_b_in};
		end
	end

	wire pa_rise = pa_s[1] & ~pa_s[2];
	wire pa_fall = ~pa_s[1] & pa_s[2];
	wire pb_rise = pb_s[1] & ~pb_s[2];
	wire pb_fall = ~pb_s[1] & pb_s[2];
	wire [1:0] sel_a = edge_sel[`IRC_EDGE_A_LSB +: 2];
	wire [1:0] sel_b = edge_sel[`IRC_EDGE_B_LSB +: 2];
	wire pa_ev = (sel_a[0] & pa_rise) | (sel_a[1] & pa_fall);
	wire pb_ev = (sel_b[0] & pb_rise) | (sel_b[1] & pb_fall);

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait, always OKAY, write lands in the data phase
	wire addr_go = hsel_in & hready_in & htrans_in[1];
	wire [7:0] ra = haddr_in[7:0];
	wire [7:0] wd = hwdata_in[7:0];
	wire [3:0] wr_prim;
	wire [5:0] wr_grp;
	wire [3:0] rh_prim;
	wire [5:0] rh_grp;
	wire wr_edge = wr_q & (wa_q == `IRC_OFF_EDGE);
	wire rh_edge = ra == `IRC_OFF_EDGE;
	logic [3:0][7:0] prim_rd;
	logic [5:0][7:0] grp_rd;
	wire [7:0] edge_rd = {4'h0, edge_sel};
	// Unmapped addresses hit nothing and read zero
	wire [7:0] rd_byte = (rh_edge ? edge_rd : 8'h00) | or_prim(rh_prim, prim_rd)
		| or_grp(rh_grp, grp_rd);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_q <= 1'b0;
			wa_q <= `IRC_RST_REG;
			hrdata_out <= `IRC_RST_RDATA;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			wr_q <= addr_go & hwrite_in;
			wa_q <= addr_go ? ra : wa_q;
			hrdata_out <= (addr_go & ~hwrite_in) ? {24'h0, rd_byte} : `IRC_RST_RDATA;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	function automatic irc_byte_t or_prim(input logic [3:0] h, input logic [3:0][7:0] v);
		irc_byte_t b;
		b = 8'h00;
		for (int k = 0; k < 4; k++) begin
			b = b | (h[k] ? v[k] : 8'h00);
		end
		return b;
	endfunction

	function automatic irc_byte_t or_grp(input logic [5:0] h, input logic [5:0][7:0] v);
		irc_byte_t b;
		b = 8'h00;
		for (int k = 0; k < 6; k++) begin
			b = b | (h[k] ? v[k] : 8'h00);
		end
		return b;
	endfunction

	// Flag and enable pairs share a register; enable four below its flag, three in control 0
	function automatic irc_byte_t prim_byte(input logic [1:0] r, input logic [13:0] f,
		input logic [13:0] e);
		irc_byte_t b;
		b = 8'h00;
		for (int i = 0; i < 14; i++) begin
			if (PREG[i] == r) begin
				b[PBIT[i]] = f[i];
				b[PBIT[i] - ((r == 2'h0) ? `IRC_EN_SHIFT0 : `IRC_EN_SHIFT)] = e[i];
			end
		end
		return b;
	endfunction

	generate
		for (genvar r = 0; r < 4; r++) begin : g_prim_reg
			localparam logic [7:0] OFF = `IRC_OFF_CTRL0 + 8'(r) * `IRC_REG_STRIDE;
			assign wr_prim[r] = wr_q & (wa_q == OFF);
			assign rh_prim[r] = ra == OFF;
			if (r == 0) begin : g_gie
				assign prim_rd[r] = prim_byte(2'(r), pflag, penable) | {7'h00, gie};
			end else begin : g_plain
				assign prim_rd[r] = prim_byte(2'(r), pflag, penable);
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			edge_sel <= 4'h0;
		end else if (wr_edge) begin
			edge_sel <= wd[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Group registers and member flags
	wire [5:0] grp_set;
	wire [13:0] ev_prim;

	generate
		for (genvar g = 0; g < 6; g++) begin : g_grp
			localparam logic [7:0] OFF = `IRC_OFF_GRP0 + 8'(g) * `IRC_REG_STRIDE;
			wire [2:0] mev = member_event_in[g*3 +: 3] & SLOTS[g];
			assign wr_grp[g] = wr_q & (wa_q == OFF);
			assign rh_grp[g] = ra == OFF;
			assign grp_rd[g] = {1'b0, mflag[g], 1'b0, men[g]};
			assign grp_set[g] = |(mev & men[g]);
			assign ev_prim[GPRIM[g]] = grp_set[g];
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					mflag[g] <= 3'h0;
					men[g] <= 3'h0;
				end else begin
					// Member event wins over a software clear in the same cycle
					mflag[g] <= SLOTS[g] & (mev | (wr_grp[g] ? wd[`IRC_GRP_FLAG_LSB +: 3]
						: mflag[g]));
					men[g] <= SLOTS[g] & (wr_grp[g] ? wd[`IRC_GRP_EN_LSB +: 3] : men[g]);
				end
			end
		end
		for (genvar j = 0; j < 6; j++) begin : g_int
			assign ev_prim[INTP[j]] = int_event_in[j];
		end
	endgenerate

	assign ev_prim[`IRC_PIN_A_PRIM] = pa_ev;
	assign ev_prim[`IRC_PIN_B_PRIM] = pb_ev;

	////////////////////////////////////////////////////////////////////////////////
	// Primary flags; dedicated and group flags clear when the core takes the vector
	wire ack_go = irq_ack_in & irq_req_out.valid;

	generate
		for (genvar i = 0; i < 14; i++) begin : g_prim
			wire wsel = wr_prim[PREG[i]];
			wire taken = ack_go & (irq_req_out.vector == 4'(i));
			localparam int ESH = (PREG[i] == 2'h0) ? `IRC_EN_SHIFT0 : `IRC_EN_SHIFT;
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					pflag[i] <= 1'b0;
					penable[i] <= 1'b0;
				end else begin
					pflag[i] <= ev_prim[i] | (wsel ? wd[PBIT[i]] : pflag[i] & ~taken);
					penable[i] <= wsel ? wd[PBIT[i] - ESH] : penable[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gie <= 1'b0;
		end else if (ack_go) begin
			gie <= 1'b0;
		end else if (wr_prim[0]) begin
			gie <= wd[`IRC_BIT_GIE];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Vector request: lowest primary index wins
	wire [13:0] pend = pflag & penable;

	function automatic logic [3:0] first_set(input logic [13:0] v);
		logic [3:0] f;
		f = 4'h0;
		for (int i = 13; i >= 0; i--) begin
			if (v[i]) begin
				f = 4'(i);
			end
		end
		return f;
	endfunction

	assign next_req.valid = gie & (|pend) & ~ack_go;
	assign next_req.vector = first_set(pend);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_req_out <= '0;
		end else begin
			irq_req_out <= next_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_serviced;
		irq_ack_in && irq_req_out.valid;
	endsequence
	sequence s_blocked;
		!gie ##1 !irq_req_out.valid;
	endsequence

	property p_pin_a_rise;
		(pa_rise && sel_a[0]) |=> pflag[0];
	endproperty
	a_pin_a_rise: assert property (p_pin_a_rise) else $error("pin A rise lost");

	property p_pin_b_fall;
		(pb_fall && sel_b[1]) |=> pflag[1];
	endproperty
	a_pin_b_fall: assert property (p_pin_b_fall) else $error("pin B fall lost");

	property p_pin_off;
		(sel_a == 2'h0 && !wr_prim[0]) |=> !$rose(pflag[0]);
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("disabled pin set flag");

	property p_gie_gate;
		!gie |=> !irq_req_out.valid;
	endproperty
	a_gie_gate: assert property (p_gie_gate) else $error("request with gie low");

	property p_latch_disabled;
		(int_event_in[1] && !penable[3]) |=> pflag[3];
	endproperty
	a_latch_disabled: assert property (p_latch_disabled) else $error("flag not latched");

	property p_req_cause;
		irq_req_out.valid |-> (($past(pend) >> irq_req_out.vector) & 14'h0001) != 14'h0000;
	endproperty
	a_req_cause: assert property (p_req_cause) else $error("request without cause");

	property p_priority;
		irq_req_out.valid |-> (($past(pend) & ((14'h0001 << irq_req_out.vector) - 14'h0001))
			== 14'h0000);
	endproperty
	a_priority: assert property (p_priority) else $error("lower priority chosen");

	property p_service_block;
		s_serviced |=> s_blocked;
	endproperty
	a_service_block: assert property (p_service_block) else $error("nesting not blocked");

	property p_group_set;
		(member_event_in[0] && men[0][0]) |=> pflag[5];
	endproperty
	a_group_set: assert property (p_group_set) else $error("group flag not set");

	property p_edge_zero;
		(addr_go && !hwrite_in && rh_edge) |=> hrdata_out[31:4] == 28'h0000000;
	endproperty
	a_edge_zero: assert property (p_edge_zero) else $error("reserved bits nonzero");

endmodule

// ---- tb/irc_core_model.sv ----
// Core-side model: takes the presented vector after a chosen delay and records it.
// Assumes the request struct of irc_pkg and the one system clock of the block.
`timescale 1ns/1ns
module irc_core_model import irc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic en_in,
	input wire logic [3:0] delay_in,
	input wire irc_req_s req_in,
	output logic ack_out,
	output logic [3:0] last_vec_out,
	output logic [7:0] n_acks_out
);
	logic [3:0] wait_cnt;
	logic [1:0] gap;

	// Gap after an ack lets the registered request drop before it is looked at again
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_out <= 1'b0;
			wait_cnt <= 4'h0;
			gap <= 2'h0;
			last_vec_out <= 4'h0;
			n_acks_out <= 8'h00;
		end else begin
			ack_out <= 1'b0;
			if (gap != 2'h0) begin
				gap <= gap - 2'h1;
			end else if (en_in && req_in.valid) begin
				if (wait_cnt == delay_in) begin
					ack_out <= 1'b1;
					wait_cnt <= 4'h0;
					gap <= 2'h3;
					last_vec_out <= req_in.vector;
					n_acks_out <= n_acks_out + 8'h01;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule

// ---- tb/tb_interrupt_request_control.sv ----
// Self-checking bench of the interrupt request control: registers, events, pins, core acks.
// Assumes the design files and the core model are compiled before it.
`timescale 1ns/1ns
module tb_interrupt_request_control import irc_pkg::*; ();
	logic clk, rst, hsel, hwrite, rdy, hresp, ack, ack_en;
	logic [1:0] htrans, pins;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, rdata, rd_q, tmp;
	logic [5:0] int_ev;
	logic [17:0] mem_ev;
	logic [3:0] dly, last_vec;
	logic [7:0] n_acks, n0;
	irc_req_s req;
	int fails, n_checks, cyc;
	localparam logic [7:0] MASK [11] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h77, 8'h33, 8'h33,
		8'h33, 8'h77, 8'h77, 8'h33};

	irc_interrupt_request_control dut_u (.ref_clk_in(clk), .rst_in(rst), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hready_in(rdy), .hwdata_in(hwdata), .hrdata_out(rdata), .hreadyout_out(rdy),
		.hresp_out(hresp), .ext_irq_pin_a_in(pins[0]), .ext_irq_pin_b_in(pins[1]),
		.int_event_in(int_ev), .member_event_in(mem_ev), .irq_ack_in(ack), .irq_req_out(req));
	irc_core_model core_u (.clk_in(clk), .rst_in(rst), .en_in(ack_en), .delay_in(dly),
		.req_in(req), .ack_out(ack), .last_vec_out(last_vec), .n_acks_out(n_acks));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Read data is taken as it stood just before the closing edge
	always @(posedge clk) rd_q <= rdata;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task summarize();
		$display("checks %0d errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		do @(posedge clk); while (rdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		do @(posedge clk); while (rdy !== 1'b1);
		#1 r = rd_q;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		ahb(1'b1, a, d, tmp);
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		ahb(1'b0, a, 8'h00, tmp);
		chk(tmp, {24'h000000, exp});
	endtask
	task pulse(input logic [5:0] i, input logic [17:0] m);
		@(posedge clk);
		int_ev <= i;
		mem_ev <= m;
		@(posedge clk);
		int_ev <= 6'h00;
		mem_ev <= 18'h00000;
	endtask
	task wait_ack(input logic [7:0] old);
		for (int k = 0; k < 60 && n_acks === old; k++) @(posedge clk);
		#1 chk({24'h000000, n_acks}, {24'h000000, old + 8'h01});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_reset();
		for (int i = 0; i < 12; i++) rd_chk(8'(i * 4), 8'h00);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task t_masks();
		for (int i = 0; i < 11; i++) wr(8'(i * 4), 8'hFF);
		for (int i = 0; i < 11; i++) rd_chk(8'(i * 4), MASK[i]);
		for (int i = 0; i < 11; i++) wr(8'(i * 4), 8'h00);
		rd_chk(8'h04, 8'h00);
	endtask
	task t_disabled();
		wr(8'h04, 8'h01);
		pulse(6'h02, 18'h00000);
		repeat (3) @(posedge clk);
		#1 chk({31'h0, req.valid}, 32'h0);
		rd_chk(8'h08, 8'h10);
		wr(8'h08, 8'h00);
	endtask
	task t_prio();
		ack_en <= 1'b1;
		dly <= 4'h2;
		n0 = n_acks;
		wr(8'h08, 8'h03);
		pulse(6'h06, 18'h00000);
		wait_ack(n0);
		chk({28'h0, last_vec}, 32'h3);
		repeat (3) @(posedge clk);
		#1 chk({31'h0, req.valid}, 32'h0);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h08, 8'h23);
		dly <= 4'h9;
		n0 = n_acks;
		wr(8'h04, 8'h01);
		wait_ack(n0);
		chk({28'h0, last_vec}, 32'h4);
		rd_chk(8'h08, 8'h03);
	endtask
	task t_pins();
		for (int p = 0; p < 2; p++) begin
			for (int m = 0; m < 4; m++) begin
				wr(8'h00, 8'(m << (2 * p)));
				pins[p] <= 1'b1;
				repeat (6) @(posedge clk);
				rd_chk(8'h04, {7'h00, m[0]} << (5 + p));
				wr(8'h04, 8'h00);
				pins[p] <= 1'b0;
				repeat (6) @(posedge clk);
				rd_chk(8'h04, {7'h00, m[1]} << (5 + p));
				wr(8'h04, 8'h00);
			end
		end
		wr(8'h00, 8'h00);
	endtask
	task t_group();
		dly <= 4'h0;
		wr(8'h20, 8'h04);
		wr(8'h10, 8'h01);
		wr(8'h04, 8'h01);
		pulse(6'h00, 18'h00200);
		rd_chk(8'h10, 8'h01);
		n0 = n_acks;
		pulse(6'h00, 18'h00800);
		wait_ack(n0);
		chk({28'h0, last_vec}, 32'hB);
		rd_chk(8'h20, 8'h54);
		rd_chk(8'h10, 8'h01);
		wr(8'h14, 8'h01);
		pulse(6'h00, 18'h00001);
		rd_chk(8'h08, 8'h43);
		rd_chk(8'h14, 8'h11);
	endtask

	initial begin
		{hsel, hwrite, ack_en, cyc, fails, n_checks} = '0;
		{htrans, pins, haddr, hwdata, int_ev, mem_ev, dly} = '0;
		hsize = 3'b010;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_masks();
		t_disabled();
		t_prio();
		t_pins();
		t_group();
		summarize();
	end
endmodule
